// ### hdl/cfr_regs_top.sv
// Converter fault, mask, control and reference register bank.
// Assumes a byte-wide register port from a serial engine on clk_sys,
// and asynchronous fault and supervisor pins from the analog side.
//
// Function
// (RULE1) Status bits 7 to 5 read zero
// (RULE2) Status bit 4 shows live power-good
// (RULE3) Status bit 3 flags detected overvoltage
// (RULE4) Status bit 2 flags hard-short latch-off
// (RULE5) Status bit 1 flags thermal latch-off
// (RULE6) Status bit 0 flags overcurrent latch-off
// (RULE7) Mask bit 4 masks power-good, resets 0
// (RULE8) Mask bit 3 masks overvoltage, resets 1
// (RULE9) Mask bit 2 masks hard-short, resets 1
// (RULE10) Mask bit 1 masks thermal, resets 1
// (RULE11) Mask bit 0 masks overcurrent, resets 1
// (RULE12) Control bits 7:5 compensation, resets 010
// (RULE13) Control bits 4:3 frequency, resets 10
// (RULE14) Control bits 2:0 current limit, resets 000
// (RULE15) Reference codes up to 0x3C clamp low
// (RULE16) Codes 0x3D to 0xCC linear 4.9mV steps
// (RULE17) Codes from 0xCD clamp at 1.000V
// (RULE18) Shutdown returns registers to defaults
// (RULE19) Enable, supply or undervoltage loss means shutdown
// (RULE20) Host writes pointer then byte, takes effect
// (RULE21) Writes to status register are ignored
// (RULE22) Alert while any unmasked flag set
`timescale 1ns/1ps
module cfr_regs_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port from the serial engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Analog comparator and supervisor pins
  input wire logic pin_overcurrent,
  input wire logic pin_thermal,
  input wire logic pin_hard_short,
  input wire logic pin_overvoltage,
  input wire logic pin_power_good,
  input wire logic pin_enable,
  input wire logic pin_vio_valid,
  input wire logic pin_uvlo,
  // Converter settings
  output logic [2:0] comp_select,
  output logic [1:0] switching_frequency_select,
  output logic [2:0] current_limit_select,
  output logic [11:0] switching_frequency_khz,
  output logic [9:0] current_limit_10ma,
  output logic [19:0] reference_uv,
  // Status outputs
  output logic status_alert,
  output logic converter_shutdown
);

  // Register select, shared by the write and read paths
  function automatic cfr_pkg::cfr_sel_e reg_select(input logic [7:0] addr);
    case (addr)
      cfr_pkg::ADDR_FAULT_STATUS: return cfr_pkg::CFR_SEL_STATUS;
      cfr_pkg::ADDR_FAULT_MASK: return cfr_pkg::CFR_SEL_MASK;
      cfr_pkg::ADDR_CONTROL_A: return cfr_pkg::CFR_SEL_CONTROL;
      cfr_pkg::ADDR_REFERENCE: return cfr_pkg::CFR_SEL_REFERENCE;
      default: return cfr_pkg::CFR_SEL_NONE;
    endcase
  endfunction : reg_select

  // Code to microvolts, clamped at both ends
  function automatic logic [19:0] reference_decode(input logic [7:0] code);
    logic [19:0] steps;
    steps = {12'h000, code - cfr_pkg::REF_CODE_LIN_LO};
    if (code < cfr_pkg::REF_CODE_LIN_LO) begin
      return cfr_pkg::REF_MIN_UV; // RULE15
    end else if (code > cfr_pkg::REF_CODE_LIN_HI) begin
      return cfr_pkg::REF_MAX_UV; // RULE17
    end else begin
      return 20'(cfr_pkg::REF_MIN_UV + 20'(steps * cfr_pkg::REF_STEP_UV)); // RULE16
    end
  endfunction : reference_decode

  cfr_flag_if flag_bus();

  cfr_fault_sync u_fault_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_overcurrent(pin_overcurrent),
    .pin_thermal(pin_thermal),
    .pin_hard_short(pin_hard_short),
    .pin_overvoltage(pin_overvoltage),
    .pin_power_good(pin_power_good),
    .pin_enable(pin_enable),
    .pin_vio_valid(pin_vio_valid),
    .pin_uvlo(pin_uvlo),
    .flags(flag_bus)
  );

  cfr_pkg::cfr_sel_e wr_sel;
  cfr_pkg::cfr_sel_e rd_sel;
  logic shutdown;
  logic [cfr_pkg::NUM_FAULTS-1:0] flag_q;
  logic pok_q;
  logic [cfr_pkg::NUM_FLAGS-1:0] mask_q;
  logic [7:0] control_q;
  logic [7:0] reference_q;
  logic [7:0] status_vec;
  logic [cfr_pkg::NUM_FLAGS-1:0] alert_vec;
  logic [7:0] read_mux;
  logic [7:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic status_alert_q;
  logic shutdown_q;
  logic [11:0] switching_frequency_select_khz_q;
  logic [9:0] current_limit_select_10ma_q;
  logic [19:0] reference_uv_q;

  assign wr_sel = reg_select(reg_addr);
  assign rd_sel = reg_select(reg_addr);
  assign shutdown = flag_bus.shutdown;

  // Fault flags latch until shutdown; a new event in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_bus.fault_seen | (flag_q & {cfr_pkg::NUM_FAULTS{!shutdown}}); // RULE3 RULE4 RULE5 RULE6 RULE18
    end
  end

  // Power-good is a live level, not sticky
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pok_q <= 1'b0;
    end else begin
      pok_q <= flag_bus.power_good; // RULE2
    end
  end

  // Status has no write path at all
  assign status_vec = {cfr_pkg::STATUS_RSVD_VALUE, pok_q, flag_q}; // RULE1 RULE21

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= cfr_pkg::RST_FAULT_MASK; // RULE7 RULE8 RULE9 RULE10 RULE11
    end else if (shutdown) begin
      mask_q <= cfr_pkg::RST_FAULT_MASK; // RULE18
    end else if (reg_wr && wr_sel == cfr_pkg::CFR_SEL_MASK) begin
      mask_q <= reg_wdata[cfr_pkg::NUM_FLAGS-1:0]; // RULE20
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= cfr_pkg::RST_CONTROL_A; // RULE12 RULE13 RULE14
    end else if (shutdown) begin
      control_q <= cfr_pkg::RST_CONTROL_A; // RULE18
    end else if (reg_wr && wr_sel == cfr_pkg::CFR_SEL_CONTROL) begin
      control_q <= reg_wdata; // RULE20
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reference_q <= cfr_pkg::RST_REFERENCE;
    end else if (shutdown) begin
      reference_q <= cfr_pkg::RST_REFERENCE; // RULE18
    end else if (reg_wr && wr_sel == cfr_pkg::CFR_SEL_REFERENCE) begin
      reference_q <= reg_wdata; // RULE20
    end
  end

  always_comb begin
    case (rd_sel)
      cfr_pkg::CFR_SEL_STATUS: read_mux = status_vec;
      cfr_pkg::CFR_SEL_MASK: read_mux = {3'h0, mask_q};
      cfr_pkg::CFR_SEL_CONTROL: read_mux = control_q;
      cfr_pkg::CFR_SEL_REFERENCE: read_mux = reference_q;
      default: read_mux = cfr_pkg::READ_UNMAPPED;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= cfr_pkg::READ_UNMAPPED;
    end else if (reg_rd) begin
      reg_rdata_q <= read_mux;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
    end
  end

  // Masked flags stay readable; only the alert is gated
  assign alert_vec = {pok_q, flag_q} & ~mask_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_alert_q <= 1'b0;
    end else begin
      status_alert_q <= |alert_vec; // RULE22
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_q <= 1'b1;
    end else begin
      shutdown_q <= shutdown;
    end
  end

  // Decoded settings lag the register by one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      switching_frequency_select_khz_q <= cfr_pkg::SWITCHING_FREQUENCY_SELECT_KHZ_TABLE[cfr_pkg::RST_CONTROL_A[cfr_pkg::SWITCHING_FREQUENCY_SELECT_MSB:cfr_pkg::SWITCHING_FREQUENCY_SELECT_LSB]];
      current_limit_select_10ma_q <= cfr_pkg::CURRENT_LIMIT_SELECT_10MA_TABLE[cfr_pkg::RST_CONTROL_A[cfr_pkg::CURRENT_LIMIT_SELECT_MSB:cfr_pkg::CURRENT_LIMIT_SELECT_LSB]];
    end else begin
      switching_frequency_select_khz_q <= cfr_pkg::SWITCHING_FREQUENCY_SELECT_KHZ_TABLE[control_q[cfr_pkg::SWITCHING_FREQUENCY_SELECT_MSB:cfr_pkg::SWITCHING_FREQUENCY_SELECT_LSB]]; // RULE13
      current_limit_select_10ma_q <= cfr_pkg::CURRENT_LIMIT_SELECT_10MA_TABLE[control_q[cfr_pkg::CURRENT_LIMIT_SELECT_MSB:cfr_pkg::CURRENT_LIMIT_SELECT_LSB]]; // RULE14
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reference_uv_q <= reference_decode(cfr_pkg::RST_REFERENCE);
    end else begin
      reference_uv_q <= reference_decode(reference_q); // RULE15 RULE16 RULE17
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign reg_rvalid = reg_rvalid_q;
  assign comp_select = control_q[cfr_pkg::COMP_MSB:cfr_pkg::COMP_LSB]; // RULE12
  assign switching_frequency_select = control_q[cfr_pkg::SWITCHING_FREQUENCY_SELECT_MSB:cfr_pkg::SWITCHING_FREQUENCY_SELECT_LSB];
  assign current_limit_select = control_q[cfr_pkg::CURRENT_LIMIT_SELECT_MSB:cfr_pkg::CURRENT_LIMIT_SELECT_LSB];
  assign switching_frequency_khz = switching_frequency_select_khz_q;
  assign current_limit_10ma = current_limit_select_10ma_q;
  assign reference_uv = reference_uv_q;
  assign status_alert = status_alert_q;
  assign converter_shutdown = shutdown_q;

  AST_STATUS_READBACK: assert property ( // RULE1
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && rd_sel == cfr_pkg::CFR_SEL_STATUS) |=>
      (reg_rvalid && reg_rdata[7:5] == cfr_pkg::STATUS_RSVD_VALUE && reg_rdata == $past(status_vec))
  ) else $error("Status readback wrong or reserved bits nonzero");

  AST_POWER_GOOD_TRACKS_PIN: assert property ( // RULE2
    @(posedge clk_sys) disable iff (!rst_n)
    pin_power_good [*4] |-> pok_q
  ) else $error("Power-good pin high but status bit low");

  AST_OVERVOLTAGE_STICKY: assert property ( // RULE3
    @(posedge clk_sys) disable iff (!rst_n)
    (flag_q[cfr_pkg::BIT_OVERVOLTAGE] && !shutdown) |=> flag_q[cfr_pkg::BIT_OVERVOLTAGE]
  ) else $error("Overvoltage flag lost without shutdown");

  AST_OVERCURRENT_SETS: assert property ( // RULE6
    @(posedge clk_sys) disable iff (!rst_n)
    pin_overcurrent [*3] |=> flag_q[cfr_pkg::BIT_OVERCURRENT] && status_vec[cfr_pkg::BIT_OVERCURRENT]
  ) else $error("Overcurrent pin high but flag not set");

  AST_THERMAL_SETS: assert property ( // RULE5
    @(posedge clk_sys) disable iff (!rst_n)
    pin_thermal [*3] |=> flag_q[cfr_pkg::BIT_THERMAL]
  ) else $error("Thermal pin high but flag not set");

  AST_SHUTDOWN_DEFAULTS: assert property ( // RULE18
    @(posedge clk_sys) disable iff (!rst_n)
    (shutdown && flag_bus.fault_seen == '0) |=>
      (mask_q == cfr_pkg::RST_FAULT_MASK && control_q == cfr_pkg::RST_CONTROL_A
       && reference_q == cfr_pkg::RST_REFERENCE && flag_q == '0)
  ) else $error("Registers not at defaults after shutdown");

  AST_MASK_WRITE: assert property ( // RULE20
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && wr_sel == cfr_pkg::CFR_SEL_MASK && !shutdown) |=>
      mask_q == $past(reg_wdata[cfr_pkg::NUM_FLAGS-1:0])
  ) else $error("Mask write did not take effect");

  AST_STATUS_WRITE_IGNORED: assert property ( // RULE21
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && wr_sel == cfr_pkg::CFR_SEL_STATUS && !shutdown && flag_bus.fault_seen == '0) |=>
      flag_q == $past(flag_q)
  ) else $error("Status flags changed by a write");

  AST_REFERENCE_CLAMP_LOW: assert property ( // RULE15
    @(posedge clk_sys) disable iff (!rst_n)
    (reference_q < cfr_pkg::REF_CODE_LIN_LO) |=> reference_uv == cfr_pkg::REF_MIN_UV
  ) else $error("Low reference code not clamped");

  AST_REFERENCE_CLAMP_HIGH: assert property ( // RULE17
    @(posedge clk_sys) disable iff (!rst_n)
    (reference_q > cfr_pkg::REF_CODE_LIN_HI) |=> reference_uv == cfr_pkg::REF_MAX_UV
  ) else $error("High reference code not clamped");

  AST_REFERENCE_STEP: assert property ( // RULE16
    @(posedge clk_sys) disable iff (!rst_n)
    (reference_q == cfr_pkg::REF_CODE_LIN_LO + 8'h01) |=>
      reference_uv == cfr_pkg::REF_MIN_UV + cfr_pkg::REF_STEP_UV
  ) else $error("Reference step size wrong");

  AST_FREQUENCY_DEFAULT: assert property ( // RULE13
    @(posedge clk_sys) disable iff (!rst_n)
    shutdown [*2] |=> switching_frequency_khz == cfr_pkg::SWITCHING_FREQUENCY_SELECT_KHZ_TABLE[2]
  ) else $error("Default switching frequency wrong");

  AST_ALERT_UNMASKED: assert property ( // RULE22
    @(posedge clk_sys) disable iff (!rst_n)
    (flag_q[cfr_pkg::BIT_HARD_SHORT] && !mask_q[cfr_pkg::BIT_HARD_SHORT]) |=> status_alert
  ) else $error("Unmasked flag did not raise alert");

  AST_ALERT_QUIET: assert property ( // RULE22
    @(posedge clk_sys) disable iff (!rst_n)
    ({pok_q, flag_q} & ~mask_q) == '0 |=> !status_alert
  ) else $error("Alert raised with every flag masked or clear");

endmodule : cfr_regs_top

// ### hdl/cfr_pkg.sv
// Constants for the converter fault and control register bank.
// Assumes a single 25 MHz system clock; all users write cfr_pkg::name.
package cfr_pkg;

  // Register pointers
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FAULT_MASK = 8'h11;
  localparam logic [7:0] ADDR_CONTROL_A = 8'h12;
  localparam logic [7:0] ADDR_REFERENCE = 8'h13;

  // Flag bit positions, shared by status and mask
  localparam int unsigned NUM_FAULTS = 4;
  localparam int unsigned NUM_FLAGS = 5;
  localparam int unsigned BIT_POWER_GOOD = 4;
  localparam int unsigned BIT_OVERVOLTAGE = 3;
  localparam int unsigned BIT_HARD_SHORT = 2;
  localparam int unsigned BIT_THERMAL = 1;
  localparam int unsigned BIT_OVERCURRENT = 0;
  localparam logic [2:0] STATUS_RSVD_VALUE = 3'h0;

  // Control register fields
  localparam int unsigned COMP_MSB = 7;
  localparam int unsigned COMP_LSB = 5;
  localparam int unsigned SWITCHING_FREQUENCY_SELECT_MSB = 4;
  localparam int unsigned SWITCHING_FREQUENCY_SELECT_LSB = 3;
  localparam int unsigned CURRENT_LIMIT_SELECT_MSB = 2;
  localparam int unsigned CURRENT_LIMIT_SELECT_LSB = 0;

  // Reset values
  localparam logic [4:0] RST_FAULT_MASK = 5'h0f;
  localparam logic [7:0] RST_CONTROL_A = 8'h50;
  localparam logic [7:0] RST_REFERENCE = 8'h44;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Switching frequency in kHz, indexed by field code
  localparam logic [11:0] SWITCHING_FREQUENCY_SELECT_KHZ_TABLE [0:3] = '{12'h4b0, 12'h5dc, 12'h708, 12'h834};
  // High-side current limit in 10 mA units, indexed by field code
  localparam logic [9:0] CURRENT_LIMIT_SELECT_10MA_TABLE [0:7] = '{10'h2bc, 10'h26c, 10'h230, 10'h1cc,
                                                    10'h17c, 10'h118, 10'h0b4, 10'h063};

  // Reference transfer function, microvolts
  localparam logic [7:0] REF_CODE_LIN_LO = 8'h3d;
  localparam logic [7:0] REF_CODE_LIN_HI = 8'hcc;
  localparam logic [19:0] REF_MIN_UV = 20'h4_8ff8;
  localparam logic [19:0] REF_MAX_UV = 20'hf_4240;
  localparam logic [19:0] REF_STEP_UV = 20'h0_1324;

  // Pin synchroniser lanes
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned PIN_OVERCURRENT = 0;
  localparam int unsigned PIN_THERMAL = 1;
  localparam int unsigned PIN_HARD_SHORT = 2;
  localparam int unsigned PIN_OVERVOLTAGE = 3;
  localparam int unsigned PIN_POWER_GOOD = 4;
  localparam int unsigned PIN_ENABLE = 5;
  localparam int unsigned PIN_VIO_VALID = 6;
  localparam int unsigned PIN_UVLO = 7;

  typedef enum logic [2:0] {
    CFR_SEL_NONE,
    CFR_SEL_STATUS,
    CFR_SEL_MASK,
    CFR_SEL_CONTROL,
    CFR_SEL_REFERENCE
  } cfr_sel_e;

endpackage : cfr_pkg

// ### hdl/cfr_flag_if.sv
// Synchronised fault and supervisor levels between pin sampler and register bank.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface cfr_flag_if;
  logic [cfr_pkg::NUM_FAULTS-1:0] fault_seen;
  logic power_good;
  logic shutdown;

  modport src (
    output fault_seen,
    output power_good,
    output shutdown
  );

  modport dst (
    input fault_seen,
    input power_good,
    input shutdown
  );
endinterface : cfr_flag_if

// ### hdl/cfr_fault_sync.sv
// Two-flop synchronisers for comparator and supervisor pins, plus shutdown decode.
// Assumes pins are asynchronous levels from the analog side.
`timescale 1ns/1ps
module cfr_fault_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Asynchronous pins
  input wire logic pin_overcurrent,
  input wire logic pin_thermal,
  input wire logic pin_hard_short,
  input wire logic pin_overvoltage,
  input wire logic pin_power_good,
  input wire logic pin_enable,
  input wire logic pin_vio_valid,
  input wire logic pin_uvlo,
  // Synchronised levels
  cfr_flag_if.src flags
);

  logic [cfr_pkg::NUM_PINS-1:0] raw;
  logic [cfr_pkg::NUM_PINS-1:0] sync1_q;
  logic [cfr_pkg::NUM_PINS-1:0] sync2_q;

  assign raw = {pin_uvlo, pin_vio_valid, pin_enable, pin_power_good,
                pin_overvoltage, pin_hard_short, pin_thermal, pin_overcurrent};

  for (genvar i = 0; i < cfr_pkg::NUM_PINS; i++) begin : g_sync
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  assign flags.fault_seen = sync2_q[cfr_pkg::PIN_OVERVOLTAGE:cfr_pkg::PIN_OVERCURRENT];
  assign flags.power_good = sync2_q[cfr_pkg::PIN_POWER_GOOD];
  // Any supervisor loss counts as shutdown
  assign flags.shutdown = !sync2_q[cfr_pkg::PIN_ENABLE] || !sync2_q[cfr_pkg::PIN_VIO_VALID] // RULE19
                          || sync2_q[cfr_pkg::PIN_UVLO];

  AST_SHUTDOWN_ON_ENABLE_LOW: assert property ( // RULE19
    @(posedge clk_sys) disable iff (!rst_n)
    !pin_enable [*3] |-> flags.shutdown
  ) else $error("Enable held low but shutdown not seen");

endmodule : cfr_fault_sync

// ### tb/cfr_host_model.sv
// Host side of the register byte port, standing in for the serial bus master.
// Assumes the bank samples requests on the rising edge of clk_sys.
`timescale 1ns/1ps
module cfr_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Pointer and byte go out together for one edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    // Stale byte inverted so a late sample cannot pass by luck
    reg_wdata = ~data;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    ok = 1'b0;
    data = 8'h00;
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = addr;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (reg_rvalid === 1'b1) begin
        data = reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge clk_sys);
      end
    end
  endtask : rd
endmodule : cfr_host_model

// ### tb/tb.sv
// Self-checking bench for the converter register bank.
// Assumes the host model drives the byte port; pins are driven here.
`timescale 1ns/1ps
module tb;
  logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] fault_pins;
  logic pin_power_good, pin_enable, pin_vio_valid, pin_uvlo;
  logic [2:0] comp_select, current_limit_select;
  logic [1:0] switching_frequency_select;
  logic [11:0] switching_frequency_khz;
  logic [9:0] current_limit_10ma;
  logic [19:0] reference_uv;
  logic status_alert, converter_shutdown;
  int err_total, n_tests;
  logic [9:0] current_limit_select_exp [8] = '{10'h2bc, 10'h26c, 10'h230, 10'h1cc, 10'h17c, 10'h118, 10'h0b4, 10'h063};

  cfr_regs_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pin_overcurrent(fault_pins[0]), .pin_thermal(fault_pins[1]), .pin_hard_short(fault_pins[2]),
    .pin_overvoltage(fault_pins[3]), .pin_power_good(pin_power_good), .pin_enable(pin_enable),
    .pin_vio_valid(pin_vio_valid), .pin_uvlo(pin_uvlo), .comp_select(comp_select),
    .switching_frequency_select(switching_frequency_select), .current_limit_select(current_limit_select),
    .switching_frequency_khz(switching_frequency_khz), .current_limit_10ma(current_limit_10ma),
    .reference_uv(reference_uv), .status_alert(status_alert), .converter_shutdown(converter_shutdown));

  cfr_host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  function automatic logic [19:0] ref_uv(input logic [7:0] c);
    if (c <= 8'h3c) return 20'h4_8ff8;
    if (c >= 8'hcd) return 20'hf_4240;
    return 20'(32'h0004_8ff8 + (32'(c) - 32'h0000_003d) * 32'h0000_1324);
  endfunction : ref_uv

  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(addr, d, ok);
    if (ok !== 1'b1) begin
      err_total++;
      $display("ERROR read_valid expected 1 seen 0");
      tally_and_finish();
    end else begin
      chk($sformatf("reg_%0h", addr), {12'h000, exp}, {12'h000, d});
    end
  endtask : rd_chk

  task automatic t_defaults();
    rd_chk(8'h11, 8'h0f);
    rd_chk(8'h12, 8'h50);
    rd_chk(8'h13, 8'h44);
    rd_chk(8'h10, 8'h00);
    chk("khz", 20'h0_0708, {8'h00, switching_frequency_khz});
    chk("current_limit_select", 20'h0_02bc, {10'h000, current_limit_10ma});
    chk("uv", ref_uv(8'h44), reference_uv);
  endtask : t_defaults

  task automatic t_control();
    logic [7:0] v;
    for (int c = 0; c < 8; c++) begin
      v = {3'(c), 2'(c), 3'(7 - c)};
      host.wr(8'h12, v);
      cyc(2);
      chk("comp", 20'(c), {17'h0_0000, comp_select});
      chk("switching_frequency_select_sel", 20'(c % 4), {18'h0_0000, switching_frequency_select});
      chk("current_limit_select_sel", 20'(7 - c), {17'h0_0000, current_limit_select});
      chk("khz", 20'(32'h0000_04b0 + 32'h0000_012c * (c % 4)), {8'h00, switching_frequency_khz});
      chk("current_limit_select", {10'h000, current_limit_select_exp[7 - c]}, {10'h000, current_limit_10ma});
      rd_chk(8'h12, v);
    end
  endtask : t_control

  task automatic t_reference();
    // First step above the low clamp exercises the step-size assertion
    logic [7:0] codes [8] = '{8'h00, 8'h3c, 8'h3d, 8'h3e, 8'h44, 8'hcc, 8'hcd, 8'hff};
    foreach (codes[i]) begin
      host.wr(8'h13, codes[i]);
      cyc(3);
      chk("uv", ref_uv(codes[i]), reference_uv);
      rd_chk(8'h13, codes[i]);
    end
  endtask : t_reference

  task automatic t_faults();
    pin_power_good = 1'b1;
    cyc(5);
    rd_chk(8'h10, 8'h10);
    chk("alert", 20'h0_0001, {19'h0_0000, status_alert});
    host.wr(8'h11, 8'hff);
    rd_chk(8'h11, 8'h1f);
    cyc(3);
    chk("alert", 20'h0_0000, {19'h0_0000, status_alert});
    for (int i = 0; i < 4; i++) begin
      fault_pins[i] = 1'b1;
      cyc(5);
      fault_pins[i] = 1'b0;
      // Flags latch, so they stay after the pin drops
      rd_chk(8'h10, 8'(32'h10 | ((32'h2 << i) - 1)));
      chk("alert", 20'h0_0000, {19'h0_0000, status_alert});
    end
    host.wr(8'h10, 8'h00);
    rd_chk(8'h10, 8'h1f);
    // Overvoltage and hard-short unmasked together
    host.wr(8'h11, 8'h13);
    cyc(3);
    chk("alert", 20'h0_0001, {19'h0_0000, status_alert});
    pin_power_good = 1'b0;
    cyc(5);
    rd_chk(8'h10, 8'h0f);
    rd_chk(8'h14, 8'h00);
  endtask : t_faults

  task automatic t_shutdown();
    for (int k = 0; k < 3; k++) begin
      host.wr(8'h11, 8'h00);
      host.wr(8'h12, 8'h1b);
      host.wr(8'h13, 8'hff);
      pin_enable = (k != 0);
      pin_vio_valid = (k != 1);
      pin_uvlo = (k == 2);
      cyc(4);
      chk("shutdown", 20'h0_0001, {19'h0_0000, converter_shutdown});
      pin_enable = 1'b1;
      pin_vio_valid = 1'b1;
      pin_uvlo = 1'b0;
      cyc(4);
      chk("shutdown", 20'h0_0000, {19'h0_0000, converter_shutdown});
      rd_chk(8'h11, 8'h0f);
      rd_chk(8'h12, 8'h50);
      rd_chk(8'h13, 8'h44);
      rd_chk(8'h10, 8'h00);
      chk("khz", 20'h0_0708, {8'h00, switching_frequency_khz});
    end
  endtask : t_shutdown

  initial begin
    err_total = 0;
    n_tests = 0;
    rst_n = 1'b0;
    fault_pins = 4'h0;
    pin_power_good = 1'b0;
    pin_enable = 1'b1;
    pin_vio_valid = 1'b1;
    pin_uvlo = 1'b0;
    cyc(10);
    rst_n = 1'b1;
    cyc(4);
    t_defaults();
    t_control();
    t_reference();
    t_faults();
    t_shutdown();
    tally_and_finish();
  end
endmodule : tb
